//--- rtl/ebo_pkg.sv
// Package for the expanded blit and scanline order engine
package ebo_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_DEST      = 8'h08;
	localparam logic [7:0] OFS_SRC       = 8'h0C;
	localparam logic [7:0] OFS_WARP      = 8'h10;
	localparam logic [7:0] OFS_FACTOR    = 8'h14;
	localparam logic [7:0] OFS_OFFSET    = 8'h18;
	localparam logic [7:0] OFS_FRAME     = 8'h1C;
	localparam logic [7:0] OFS_BAND      = 8'h20;
	localparam logic [7:0] OFS_BASE      = 8'h24;
	localparam logic [7:0] OFS_TABLE     = 8'h28;
	localparam logic [7:0] OFS_TONE      = 8'h2C;

	// Field positions
	localparam int unsigned CTRL_START   = 0;
	localparam int unsigned CTRL_PARAMS  = 1;
	localparam int unsigned CTRL_ORD_LSB = 4;
	localparam int unsigned ST_BUSY      = 0;
	localparam int unsigned ST_DONE      = 1;
	localparam int unsigned ST_FAULT     = 2;
	localparam int unsigned ST_ERR       = 3;
	localparam int unsigned HI_LSB       = 16;
	localparam int unsigned BAND_REV     = 8;

	// Upper address nibble that the engine supplies for pointers
	localparam logic [3:0]  DRAM_SEGMENT = 4'h0;
	localparam logic [27:0] TBL_STEP     = 28'h0000004;

	// Destination kinds in order code bits 3:2
	localparam logic [1:0]  DK_FRAME     = 2'h0;
	localparam logic [1:0]  DK_UNBANDED  = 2'h1;
	localparam logic [1:0]  DK_BANDED    = 2'h2;

	// Reset value and upper limit of the factors
	localparam logic [4:0]  FACTOR_RST   = 5'h01;
	localparam logic [4:0]  FACTOR_MAX   = 5'h10;

	typedef enum logic [2:0] {
		ES_IDLE, ES_SETUP, ES_XFER, ES_TFETCH, ES_RUN, ES_FAULT, ES_DONE
	} ebo_state_t;

	// One destination bit to be combined by the raster datapath
	typedef struct packed {
		logic [31:0] dst_bit;
		logic [31:0] src_bit;
		logic        tone;
		logic [31:0] tone_ptr;
	} ebo_px_t;

endpackage

//--- rtl/ebo_engine.sv
// Expanded blit and scanline order engine with AHB-Lite registers
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module ebo_engine
	import ebo_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// Destination bit stream
	output logic             px_valid,
	input  wire logic        px_ready,
	output ebo_px_t          px,
	// Scanline table fetch
	output logic             tbl_req,
	output logic [31:0]      tbl_addr,
	input  wire logic        tbl_ack,
	input  wire logic [31:0] tbl_data
);

	// Even (bit 0 cleared) DRAM pointer with internal upper nibble
	function automatic logic [31:0] ptr28(input logic [31:0] v);
		ptr28 = {DRAM_SEGMENT, v[27:1], 1'b0};
	endfunction

	// Legal horizontal factors
	function automatic logic x_ok(input logic [4:0] f);
		unique case (f)
			5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10: x_ok = 1'b1;
			default: x_ok = 1'b0;
		endcase
	endfunction

	ebo_state_t  st_r, st_nxt;

	// Order operands and control
	logic [31:0] dest_r, src_r, base_r, tbl_r, tone_r;
	logic [15:0] swarp_r, dwarp_r, expanded_x_offset_r, expanded_y_offset_r, fw_r, fh_r, bandh_r;
	logic [7:0]  bnum_r;
	logic [4:0]  xf_r, yf_r;
	logic [3:0]  order_r;
	logic        params_r, rev_r, done_r, fault_r, err_r;
	// Working counters and bus phase tracking
	logic [31:0] dst_row_r, src_row_r;
	logic [27:0] tptr_r;
	logic [15:0] col_r, row_r, bleft_r, scol_r, xq0_r, xr0_r, yr_r, run_x_r, run_len_r;
	logic [4:0]  xsub_r, ysub_r;
	logic        wr_pend_r, rd_pend_r, rd_ready_r;
	logic [7:0]  addr_r;
	// Bus decode
	wire         addr_ph  = hsel & htrans[1] & hready;
	wire         wr_en    = wr_pend_r;
	wire         wr_ctrl  = wr_en & (addr_r == OFS_CTRL);
	wire         ld_ord   = wr_ctrl & (st_r == ES_IDLE);
	wire         start    = ld_ord & hwdata[CTRL_START];
	wire [3:0]   ord_v    = ld_ord ? hwdata[CTRL_ORD_LSB +: 4] : order_r; // Start brings its code
	wire         par_v    = ld_ord ? hwdata[CTRL_PARAMS] : params_r;
	wire [31:0]  tbl_ptr  = ptr28(tbl_r);
	// Order decode
	// blit and scanline kinds
	wire [1:0]   dkind    = ord_v[3:2];
	wire         is_scan  = ord_v[1];
	wire         is_tone  = ord_v[0];
	wire         banded   = (dkind == DK_BANDED);
	wire         rev      = rev_r & banded;
	wire         y_ok     = (yf_r != 5'h00) & (yf_r <= FACTOR_MAX);
	wire         bad      = ~par_v | (dkind > DK_BANDED)
	                        | (~is_scan & ~(x_ok(xf_r) & y_ok));
	wire         empty    = (fw_r == 16'h0000) | (~is_scan & (fh_r == 16'h0000));
	// Datapath steps
	wire [31:0]  dstep    = rev ? (dst_row_r - {16'h0000, dwarp_r})
	                            : (dst_row_r + {16'h0000, dwarp_r});
	wire [31:0]  sstep    = rev ? (src_row_r - {16'h0000, swarp_r})
	                            : (src_row_r + {16'h0000, swarp_r});
	wire         px_free  = ~px_valid | px_ready;
	wire         emit     = px_free & ((st_r == ES_XFER) | (st_r == ES_RUN));
	wire         row_end  = (col_r == fw_r - 16'h0001);
	wire         last_row = (row_r == fh_r - 16'h0001);
	wire         band_hit = banded & (bleft_r == 16'h0001);
	wire         run_end  = (col_r == run_len_r - 16'h0001);
	wire         x_wrap   = ({11'h000, xsub_r} == {11'h000, xf_r} - 16'h0001);
	wire         y_wrap   = (ysub_r == yf_r - 5'h01);
	wire         ent_end  = (tbl_data == 32'h00000000);
	wire         ent_line = (tbl_data[15:0] == 16'h0000);
	wire         fault_wb = (st_r == ES_FAULT);

	// Next state
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ES_IDLE: if (start & ~bad)
				st_nxt = empty ? ES_DONE : (is_scan ? ES_TFETCH : ES_SETUP);
			ES_SETUP: if (xr0_r < {11'h000, xf_r} && yr_r < {11'h000, yf_r})
				st_nxt = ES_XFER;
			ES_XFER: if (emit & row_end)
				st_nxt = last_row ? ES_DONE : (band_hit ? ES_FAULT : ES_XFER);
			ES_TFETCH: if (tbl_ack)
				st_nxt = ent_end ? ES_DONE
				       : (ent_line ? (band_hit ? ES_FAULT : ES_TFETCH) : ES_RUN);
			ES_RUN: if (emit & run_end)
				st_nxt = ES_TFETCH;
			ES_FAULT: st_nxt = ES_IDLE;
			ES_DONE:  st_nxt = px_free ? ES_IDLE : ES_DONE;
		endcase
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			st_r <= ES_IDLE;
		else
			st_r <= st_nxt;
	end

	// Bus phase capture; reads take one wait state for a clean snapshot
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r  <= 1'b0;
			rd_pend_r  <= 1'b0;
			rd_ready_r <= 1'b0;
			addr_r     <= 8'h00;
		end else begin
			wr_pend_r  <= addr_ph & hwrite;
			rd_pend_r  <= (addr_ph & ~hwrite) | (rd_pend_r & ~rd_ready_r);
			rd_ready_r <= rd_pend_r & ~rd_ready_r;
			if (addr_ph)
				addr_r <= haddr[7:0];
		end
	end

	// Read mux; unmapped offsets read zero
	logic [31:0] rd_mux;
	always_comb begin
		unique case (addr_r)
			OFS_CTRL:   rd_mux = {24'h000000, order_r, 2'h0, params_r, 1'b0};
			OFS_STATUS: rd_mux = {28'h0000000, err_r, fault_r, done_r, st_r != ES_IDLE};
			OFS_DEST:   rd_mux = dest_r;
			OFS_SRC:    rd_mux = src_r;
			OFS_WARP:   rd_mux = {dwarp_r, swarp_r};
			OFS_FACTOR: rd_mux = {11'h000, yf_r, 11'h000, xf_r};
			OFS_OFFSET: rd_mux = {expanded_y_offset_r, expanded_x_offset_r};
			OFS_FRAME:  rd_mux = {fh_r, fw_r};
			OFS_BAND:   rd_mux = {bandh_r, 7'h00, rev_r, bnum_r};
			OFS_BASE:   rd_mux = base_r;
			OFS_TABLE:  rd_mux = tbl_r;
			OFS_TONE:   rd_mux = tone_r;
			default:    rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (rd_pend_r & ~rd_ready_r)
			hrdata <= rd_mux;
	end

	assign hreadyout = ~(rd_pend_r & ~rd_ready_r);
	assign hresp     = 1'b0;

	// Operand registers; band fault write-back overrides the bus
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			order_r <= 4'h0;    params_r <= 1'b0;
			dest_r  <= 32'h00000000; src_r <= 32'h00000000;
			swarp_r <= 16'h0000; dwarp_r <= 16'h0000;
			xf_r    <= FACTOR_RST; yf_r <= FACTOR_RST;
			expanded_x_offset_r  <= 16'h0000; expanded_y_offset_r <= 16'h0000;
			fw_r    <= 16'h0000; fh_r <= 16'h0000;
			bandh_r <= 16'h0000; rev_r <= 1'b0; bnum_r <= 8'h00;
			base_r  <= 32'h00000000; tbl_r <= 32'h00000000; tone_r <= 32'h00000000;
		end else if (fault_wb) begin
			dest_r <= dst_row_r - base_r;
			src_r  <= src_row_r;
			expanded_y_offset_r <= {11'h000, ysub_r};
			fh_r   <= fh_r - row_r;
			tbl_r  <= {DRAM_SEGMENT, tptr_r};
			bnum_r <= rev_r ? bnum_r - 8'h01 : bnum_r + 8'h01;
		end else if (wr_en && st_r == ES_IDLE) begin
			unique case (addr_r)
				OFS_CTRL: begin
					order_r  <= hwdata[CTRL_ORD_LSB +: 4];
					params_r <= hwdata[CTRL_PARAMS];
				end
				OFS_DEST:   dest_r <= hwdata;
				OFS_SRC:    src_r <= hwdata;
				OFS_WARP:   {dwarp_r, swarp_r} <= hwdata;
				OFS_FACTOR: {yf_r, xf_r} <= {hwdata[HI_LSB +: 5], hwdata[4:0]};
				OFS_OFFSET: {expanded_y_offset_r, expanded_x_offset_r} <= hwdata;
				OFS_FRAME:  {fh_r, fw_r} <= hwdata;
				OFS_BAND:   {bandh_r, rev_r, bnum_r} <=
				            {hwdata[31:16], hwdata[BAND_REV], hwdata[7:0]};
				OFS_BASE:   base_r <= hwdata;
				OFS_TABLE:  tbl_r <= hwdata;
				OFS_TONE:   tone_r <= hwdata;
				default:    ;
			endcase
		end
	end

	// Sticky status, cleared by writing one; a new event beats the clear
	wire        st_clr    = wr_en & (addr_r == OFS_STATUS);
	wire        set_done  = (st_r == ES_DONE) & px_free;
	wire        set_err   = start & bad;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_r  <= 1'b0;
			fault_r <= 1'b0;
			err_r   <= 1'b0;
		end else begin
			done_r  <= set_done | (done_r & ~(st_clr & hwdata[ST_DONE]));
			fault_r <= fault_wb | (fault_r & ~(st_clr & hwdata[ST_FAULT]));
			err_r   <= set_err | (err_r & ~(st_clr & hwdata[ST_ERR]));
		end
	end

	// Working counters for the walk over the frame or table
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dst_row_r <= 32'h00000000; src_row_r <= 32'h00000000;
			col_r <= 16'h0000; row_r <= 16'h0000; bleft_r <= 16'h0000;
			xsub_r <= 5'h00; ysub_r <= 5'h00; scol_r <= 16'h0000;
			xq0_r <= 16'h0000; xr0_r <= 16'h0000; yr_r <= 16'h0000;
			tptr_r <= 28'h0000000; run_x_r <= 16'h0000; run_len_r <= 16'h0000;
		end else begin
			unique case (st_r)
				ES_IDLE: if (start) begin
					dst_row_r <= banded ? dest_r + base_r : dest_r;
					src_row_r <= src_r;
					tptr_r  <= tbl_ptr[27:0];
					col_r   <= 16'h0000;
					row_r   <= 16'h0000;
					bleft_r <= bandh_r;
					xq0_r   <= 16'h0000;
					xr0_r   <= expanded_x_offset_r;
					yr_r    <= expanded_y_offset_r;
				end
				ES_SETUP: begin
					// Offsets divided by the factors, one step per clock
					if (xr0_r >= {11'h000, xf_r}) begin
						xr0_r <= xr0_r - {11'h000, xf_r};
						xq0_r <= xq0_r + 16'h0001;
					end else if (yr_r >= {11'h000, yf_r}) begin
						yr_r      <= yr_r - {11'h000, yf_r};
						src_row_r <= sstep;
					end else begin
						xsub_r <= xr0_r[4:0];
						scol_r <= xq0_r;
						ysub_r <= yr_r[4:0];
					end
				end
				ES_XFER: if (emit) begin
					if (row_end) begin
						col_r     <= 16'h0000;
						row_r     <= row_r + 16'h0001;
						bleft_r   <= bleft_r - 16'h0001;
						dst_row_r <= dstep;
						xsub_r    <= xr0_r[4:0];
						scol_r    <= xq0_r;
						ysub_r    <= y_wrap ? 5'h00 : ysub_r + 5'h01;
						if (y_wrap)
							src_row_r <= sstep;
					end else begin
						col_r <= col_r + 16'h0001;
						xsub_r <= x_wrap ? 5'h00 : xsub_r + 5'h01;
						if (x_wrap)
							scol_r <= scol_r + 16'h0001;
					end
				end
				ES_TFETCH: if (tbl_ack) begin
					// Reverse rendering walks the table backwards
					tptr_r    <= rev ? tptr_r - TBL_STEP : tptr_r + TBL_STEP;
					run_x_r   <= tbl_data[31:16];
					run_len_r <= tbl_data[15:0];
					col_r     <= 16'h0000;
					if (ent_line & ~ent_end) begin
						row_r     <= row_r + 16'h0001;
						bleft_r   <= bleft_r - 16'h0001;
						dst_row_r <= dstep;
					end
				end
				ES_RUN: if (emit)
					col_r <= col_r + 16'h0001;
				default: ;
			endcase
		end
	end

	// Output bit register, advanced only when the consumer is free
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			px_valid <= 1'b0;
			px       <= '0;
		end else if (px_free) begin
			px_valid <= emit;
			if (emit) begin
				px.dst_bit  <= dst_row_r + {16'h0000, (st_r == ES_RUN) ? run_x_r + col_r : col_r};
				px.src_bit  <= (st_r == ES_RUN) ? 32'h00000000
				               : src_row_r + {16'h0000, scol_r};
				px.tone     <= is_tone;
				px.tone_ptr <= ptr28(tone_r);
			end
		end
	end

	// Table fetch request
	// fault stops early
	assign tbl_req  = (st_r == ES_TFETCH);
	assign tbl_addr = {DRAM_SEGMENT, tptr_r};

endmodule

`default_nettype wire

//--- dv/ebo_engine_monitor.sv
// Port checker for the order engine
`timescale 1ns/1ps
`default_nettype none
module ebo_engine_monitor
	import ebo_pkg::*;
(
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Bus
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Stream and table
	input wire logic        px_valid,
	input wire logic        px_ready,
	input wire ebo_px_t     px,
	input wire logic        tbl_req,
	input wire logic [31:0] tbl_addr,
	input wire logic        tbl_ack
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Accepted address phases
	sequence s_rd; hsel && htrans[1] && hready && !hwrite; endsequence
	sequence s_wr; hsel && htrans[1] && hready && hwrite; endsequence
	property p_rd_wait; s_rd |=> !hreadyout ##1 hreadyout; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	property p_wr_fast; s_wr |=> hreadyout; endproperty
	a_wr_fast: assert property (p_wr_fast) else $error("write waited");
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("bad response");
	property p_tbl_hi; tbl_req |-> tbl_addr[31:28] == DRAM_SEGMENT; endproperty
	a_tbl_hi: assert property (p_tbl_hi) else $error("pointer nibble");
	property p_tbl_even; tbl_req |-> !tbl_addr[0]; endproperty
	a_tbl_even: assert property (p_tbl_even) else $error("pointer odd");
	property p_tone; px_valid |-> px.tone_ptr[31:28] == DRAM_SEGMENT && !px.tone_ptr[0]; endproperty
	a_tone: assert property (p_tone) else $error("tone pointer");
	property p_px_hold; px_valid && !px_ready |=> px_valid && $stable(px); endproperty
	a_px_hold: assert property (p_px_hold) else $error("pixel dropped");
	property p_tbl_hold; tbl_req && !tbl_ack |=> tbl_req && $stable(tbl_addr); endproperty
	a_tbl_hold: assert property (p_tbl_hold) else $error("fetch dropped");
	property p_tbl_quiet; tbl_req |=> !$rose(px_valid); endproperty
	a_tbl_quiet: assert property (p_tbl_quiet) else $error("pixel in fetch");
endmodule
bind ebo_engine ebo_engine_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.px_valid(px_valid), .px_ready(px_ready), .px(px), .tbl_req(tbl_req),
	.tbl_addr(tbl_addr), .tbl_ack(tbl_ack));
`default_nettype wire

//--- dv/ebo_dram_model.sv
// Memory-side model: pixel sink and scanline table store
`timescale 1ns/1ps
`default_nettype none
module ebo_dram_model
	import ebo_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Pace select
	input  wire logic        slow,
	// Pixel stream
	input  wire logic        px_valid,
	output logic             px_ready,
	input  wire ebo_px_t     px,
	// Table port
	input  wire logic        tbl_req,
	input  wire logic [31:0] tbl_addr,
	output logic             tbl_ack,
	output logic [31:0]      tbl_data
);
	logic [31:0] mem [logic [31:0]];
	ebo_px_t     q[$];
	logic [1:0]  cnt_r;
	// Slow pace stalls pixels and delays table words
	// words at word addresses
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			px_ready <= 1'b0;
			tbl_ack  <= 1'b0;
			tbl_data <= 32'h0;
			cnt_r    <= 2'h0;
		end else begin
			cnt_r    <= cnt_r + 2'h1;
			px_ready <= !slow || cnt_r == 2'h0;
			if (px_valid && px_ready)
				q.push_back(px);
			if (tbl_req && !tbl_ack && (!slow || cnt_r[0])) begin
				tbl_ack  <= 1'b1;
				tbl_data <= mem.exists(tbl_addr) ? mem[tbl_addr] : 32'h0;
			end else begin
				tbl_ack  <= 1'b0;
				tbl_data <= ~tbl_data;  // Stale word inverts every clock
			end
		end
	end
endmodule
`default_nettype wire

//--- dv/tb_ebo_engine.sv
// Self-checking bench for the order engine
`timescale 1ns/1ps
`default_nettype none
module tb_ebo_engine
	import ebo_pkg::*;
;
	localparam logic [31:0] DST = 32'h0000_1000;
	localparam logic [31:0] BSV = 32'h0004_0000;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic        px_valid;
	logic        px_ready;
	ebo_px_t     px;
	logic        tbl_req;
	logic [31:0] tbl_addr;
	logic        tbl_ack;
	logic [31:0] tbl_data;
	logic        slow;
	logic [31:0] rd;
	int          err_total;
	int          cmp_count;
	ebo_engine DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .px_valid(px_valid),
		.px_ready(px_ready), .px(px), .tbl_req(tbl_req), .tbl_addr(tbl_addr),
		.tbl_ack(tbl_ack), .tbl_data(tbl_data));
	ebo_dram_model u_mem (.hclk(hclk), .hresetn(hresetn), .slow(slow), .px_valid(px_valid),
		.px_ready(px_ready), .px(px), .tbl_req(tbl_req), .tbl_addr(tbl_addr),
		.tbl_ack(tbl_ack), .tbl_data(tbl_data));
	// Clock
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One single transfer; waits on hready, never on a fixed count
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic go(input logic [3:0] code);
		bus(1'b1, OFS_CTRL, {24'h0, code, 4'h3});
	endtask
	// Poll until idle, compare status, then clear it
	task automatic fin(input logic [3:0] exp);
		int n;
		n = 0;
		do begin
			bus(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while (rd[ST_BUSY] !== 1'b0 && n < 300);
		chk(rd, {28'h0, exp});
		bus(1'b1, OFS_STATUS, 32'h0000_000F);
	endtask
	task automatic pix(input logic [31:0] dst, input logic [31:0] src, input logic t);
		ebo_px_t p;
		p = '1;
		if (u_mem.q.size() != 0)
			p = u_mem.q.pop_front();
		chk(p.dst_bit, dst);
		chk(p.src_bit, src);
		chk({31'h0, p.tone}, {31'h0, t});
		chk(p.tone_ptr, 32'h0000_0206);
	endtask
	task automatic t_regs();
		rdc(OFS_FACTOR, 32'h0001_0001);
		bus(1'b1, 8'hF0, 32'hFFFF_FFFF);
		rdc(8'hF0, 32'h0);
		bus(1'b1, OFS_TONE, 32'h3000_0207);
	endtask
	task automatic t_expand();
		slow <= 1'b1;
		bus(1'b1, OFS_WARP, 32'h0100_0020);
		bus(1'b1, OFS_FACTOR, 32'h0002_0002);
		bus(1'b1, OFS_OFFSET, 32'h0001_0001);
		bus(1'b1, OFS_FRAME, 32'h0003_0004);
		bus(1'b1, OFS_DEST, DST);
		bus(1'b1, OFS_SRC, 32'h0000_8000);
		go(4'h1);
		fin(4'h2);
		for (int r = 0; r < 3; r++)
			for (int c = 0; c < 4; c++)
				pix(DST + r * 256 + c, 32'h8000 + (r + 1) / 2 * 32 + (c + 1) / 2, 1'b1);
		chk(32'(u_mem.q.size()), 32'h0);
		slow <= 1'b0;
	endtask
	task automatic one(input logic [31:0] fac, input logic ok);
		bus(1'b1, OFS_FACTOR, fac);
		go(4'h0);
		fin(ok ? 4'h2 : 4'h8);
		if (ok)
			pix(DST, 32'h8000, 1'b0);
	endtask
	task automatic t_factors();
		bus(1'b1, OFS_OFFSET, 32'h0);
		bus(1'b1, OFS_FRAME, 32'h0001_0001);
		for (int x = 0; x < 18; x++)
			one(32'h0001_0000 | x, x inside {1, 2, 3, 4, 6, 8, 12, 16});
		for (int y = 0; y < 18; y++)
			one((y << 16) | 1, y >= 1 && y <= 16);
	endtask
	task automatic t_kinds();
		bus(1'b1, OFS_BASE, BSV);
		bus(1'b1, OFS_FACTOR, 32'h0001_0001);
		bus(1'b1, OFS_BAND, 32'h0010_0000);
		u_mem.mem[32'h300] = 32'h0000_0001;
		for (int i = 0; i < 13; i++) begin
			bus(1'b1, OFS_TABLE, 32'h0000_0300);
			go(4'(i));
			fin((i == 12) ? 4'h8 : 4'h2);
			if (i < 12)
				pix((i >= 8) ? DST + BSV : DST, (i & 2) ? 32'h0 : 32'h8000, i[0]);
		end
		bus(1'b1, OFS_CTRL, 32'h0000_0001);
		fin(4'h8);
	endtask
	task automatic t_scan();
		slow <= 1'b1;
		bus(1'b1, OFS_TABLE, 32'hF000_0201);
		u_mem.mem[32'h200] = 32'h0002_0003;
		u_mem.mem[32'h204] = 32'h0001_0000;
		u_mem.mem[32'h208] = 32'h0005_0001;
		go(4'h7);
		fin(4'h2);
		for (int c = 2; c < 5; c++)
			pix(DST + c, 32'h0, 1'b1);
		pix(DST + 32'h105, 32'h0, 1'b1);
		chk(32'(u_mem.q.size()), 32'h0);
		slow <= 1'b0;
	endtask
	task automatic t_fault(input logic rev);
		int s;
		s = rev ? -1 : 1;
		bus(1'b1, OFS_FRAME, 32'h0003_0002);
		bus(1'b1, OFS_DEST, DST);
		bus(1'b1, OFS_SRC, 32'h0000_8000);
		bus(1'b1, OFS_BAND, {16'h0002, 7'h0, rev, 8'h05});
		go(4'h8);
		fin(4'h4);
		for (int r = 0; r < 2; r++)
			for (int c = 0; c < 2; c++)
				pix(DST + BSV + s * r * 256 + c, 32'h8000 + s * r * 32 + c, 1'b0);
		rdc(OFS_DEST, DST + s * 512);
		rdc(OFS_FRAME, 32'h0001_0002);
		rdc(OFS_BAND, {16'h0002, 7'h0, rev, rev ? 8'h04 : 8'h06});
	endtask
	task automatic final_report();
		if (err_total == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		slow = 1'b0;
		err_total = 0;
		cmp_count = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_expand();
		t_factors();
		t_kinds();
		t_scan();
		t_fault(1'b0);
		t_fault(1'b1);
		final_report();
	end
	// Watchdog, well beyond the expected run
	initial begin
		#200000;
		err_total++;
		final_report();
	end
endmodule
`default_nettype wire
